/* src/vcc_pkg.sv */
// shared constants and types of the voice codec
package vcc_pkg;

  // ****************************************
  // clocking
  // ****************************************
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned SAMPLE_HZ   = 64_000;
  // one codec update per 64 kHz tick; period rounds down to whole cycles
  localparam int unsigned TICK_CYCLES = CLK_HZ / SAMPLE_HZ;

  // ****************************************
  // data widths
  // ****************************************
  localparam int unsigned PCM_W       = 16;
  localparam int unsigned LOG_W       = 8;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned FEC_SEG_W   = 15;
  localparam int unsigned FEC_INFO_W  = 10;
  localparam int unsigned HIST_LEN    = 4;

  // ****************************************
  // delta modulation constants
  // ****************************************
  localparam int unsigned ACC_SHIFT   = 5;
  localparam int unsigned STEP_SHIFT  = 10;
  localparam int unsigned STEP_INT_W  = 11;
  localparam int unsigned STEP_W      = STEP_INT_W + STEP_SHIFT;
  localparam int unsigned ACC_W       = 18;
  localparam logic [STEP_INT_W-1:0]   STEP_MIN = 11'h00A;
  localparam logic [STEP_INT_W-1:0]   STEP_MAX = 11'h500;
  localparam logic signed [ACC_W-1:0] ACC_MAX  = 18'sh07FFF;
  localparam logic signed [ACC_W-1:0] ACC_MIN  = 18'sh38000;

  // ****************************************
  // log pcm constants
  // ****************************************
  localparam logic [7:0]  ALAW_SILENCE = 8'hD5;
  localparam logic [7:0]  ULAW_SILENCE = 8'hFF;
  localparam logic [7:0]  ALAW_POS     = 8'hD5;
  localparam logic [7:0]  ALAW_NEG     = 8'h55;
  localparam logic [7:0]  ULAW_POS     = 8'hFF;
  localparam logic [7:0]  ULAW_NEG     = 8'h7F;
  localparam logic [7:0]  LOG_TOP      = 8'h7F;
  localparam logic [15:0] ULAW_BIAS    = 16'h0084;
  localparam logic [15:0] ULAW_CLIP    = 16'h1FDF;
  localparam logic [15:0] ULAW_ADD     = 16'h0021;
  localparam logic [15:0] ULAW_SEG0    = 16'h0040;
  localparam logic [15:0] ALAW_SEG0    = 16'h0020;
  localparam logic [15:0] ALAW_HALF    = 16'h0008;
  localparam logic [15:0] ALAW_BIAS    = 16'h0108;

  // ****************************************
  // air coding schemes
  // ****************************************
  typedef enum logic [1:0] {
    VCC_AIR_CVSD = 2'b00,
    VCC_AIR_ALAW = 2'b01,
    VCC_AIR_ULAW = 2'b10
  } vcc_scheme_t;

endpackage

/* src/vcc_fifo.sv */
// flip-flop fifo with valid/ready on both sides
module vcc_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("vcc_fifo: DEPTH must be at least 2 and WIDTH at least 1");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    wr_d;
  logic [PW-1:0]    rd_q;
  logic [PW-1:0]    rd_d;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end

endmodule

/* src/vcc_codec.sv */
// voice codec: delta modulation and log pcm between line pcm and air bits
// ****************************************
// Functional notes
// (R01) air stream runs at 64 kb/s as log pcm or delta modulation
// (R02) link manager picks scheme before traffic; codec follows air_scheme input
// (R03) differing line and air log laws are converted per 8-bit sample
// (R04) encoder takes 64 ksample/s linear pcm; both ends update each tick
// (R05) output bit is error sign: 0 for zero or positive, 1 negative
// (R06) prediction is accumulator times (1 - 1/32) from previous period
// (R07) companding flag set when last 4 output bits all equal
// (R08) step grows by 10 up to 1280, else decays by 1/1024 floored 10
// (R09) accumulator = prediction plus signed step, clamped to 16-bit range
// (R10) accumulator output is a 16-bit signed number
// (R11) lost voice packets are replaced with fill data, no gap
// (R12) uncorrectable rate-2/3 segment passes its 10 raw information bits
// (R13) decoded reference tone lands within 1 dB of -15 dBm0
// (R14) encoder out-of-band power at least 20 dB below in-band peak
// (R15) line pcm source keeps spectrum below 4 kHz
// (R16) decoder runs the same recursion on received bits, one sample each
// (R17) decays are subtract-shift in fixed point, shared by both ends
// ****************************************
module vcc_codec #(
  parameter int unsigned TICK_CYCLES = vcc_pkg::TICK_CYCLES,
  parameter int unsigned FIFO_DEPTH  = vcc_pkg::FIFO_DEPTH
) (
  input  wire logic                           ref_clk,
  input  wire logic                           rstn,
  input  wire logic [1:0]                     air_scheme,
  input  wire logic                           line_log_mu,
  input  wire logic [vcc_pkg::PCM_W-1:0]      line_in_data,
  input  wire logic                           line_in_valid,
  output logic                                line_in_ready,
  output logic                                air_tx_bit,
  output logic                                air_tx_strobe,
  input  wire logic                           air_rx_bit,
  input  wire logic                           air_rx_strobe,
  input  wire logic                           air_rx_lost,
  output logic [vcc_pkg::PCM_W-1:0]           line_out_data,
  output logic                                line_out_valid,
  input  wire logic [vcc_pkg::FEC_SEG_W-1:0]  fec_seg,
  input  wire logic [vcc_pkg::FEC_INFO_W-1:0] fec_corrected,
  input  wire logic                           fec_uncorrectable,
  input  wire logic                           fec_seg_valid,
  output logic [vcc_pkg::FEC_INFO_W-1:0]      fec_info,
  output logic                                fec_info_valid
);

  localparam int unsigned TW    = $clog2(TICK_CYCLES);
  localparam int unsigned PCM_W = vcc_pkg::PCM_W;
  localparam int unsigned ACC_W = vcc_pkg::ACC_W;
  localparam int unsigned STW   = vcc_pkg::STEP_W;
  localparam int unsigned HL    = vcc_pkg::HIST_LEN;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 2 || FIFO_DEPTH < 2) begin : g_chk
    $error("vcc_codec: TICK_CYCLES and FIFO_DEPTH must be at least 2");
  end

  // ****************************************
  // shared arithmetic
  // ****************************************
  // prediction h*y with h = 1 - 1/32; arithmetic shift floors alike at both ends
  function automatic logic signed [ACC_W-1:0] cvsd_pred(input logic signed [ACC_W-1:0] y);
    return y - (y >>> vcc_pkg::ACC_SHIFT); // [R06] [R17]
  endfunction

  function automatic logic cvsd_alpha(input logic [HL-1:0] h);
    return (&h) | ~(|h); // [R07]
  endfunction

  // step keeps STEP_SHIFT fraction bits, else the 1/1024 decay would vanish
  function automatic logic [STW-1:0] cvsd_step(input logic [STW-1:0] st, input logic alpha);
    logic [STW-1:0] smin;
    logic [STW-1:0] smax;
    logic [STW-1:0] nxt;
    smin = {vcc_pkg::STEP_MIN, {vcc_pkg::STEP_SHIFT{1'b0}}};
    smax = {vcc_pkg::STEP_MAX, {vcc_pkg::STEP_SHIFT{1'b0}}};
    if (alpha) begin
      nxt = st + smin; // [R08]
      if (nxt > smax) nxt = smax;
    end else begin
      nxt = st - (st >> vcc_pkg::STEP_SHIFT); // [R08] [R17]
      if (nxt < smin) nxt = smin;
    end
    return nxt;
  endfunction

  // new accumulator: prediction plus signed step, saturated to 16 bits
  function automatic logic signed [ACC_W-1:0] cvsd_acc(input logic signed [ACC_W-1:0] p,
                                                      input logic b,
                                                      input logic [STW-1:0] st);
    logic signed [ACC_W-1:0] d;
    logic signed [ACC_W-1:0] yh;
    d  = signed'(ACC_W'(st >> vcc_pkg::STEP_SHIFT));
    yh = b ? p - d : p + d; // [R05] [R09]
    if (yh > vcc_pkg::ACC_MAX) yh = vcc_pkg::ACC_MAX; // [R09]
    if (yh < vcc_pkg::ACC_MIN) yh = vcc_pkg::ACC_MIN; // [R09] [R10]
    return yh;
  endfunction

  function automatic logic [7:0] lin_to_log(input logic signed [PCM_W-1:0] s, input logic mu);
    logic [15:0] m;
    logic [7:0]  mask;
    logic [3:0]  seg;
    logic [3:0]  man;
    seg = '0;
    if (mu) begin
      m    = s[PCM_W-1] ? 16'(-(s >>> 2)) : 16'(s >>> 2);
      mask = s[PCM_W-1] ? vcc_pkg::ULAW_NEG : vcc_pkg::ULAW_POS;
      if (m > vcc_pkg::ULAW_CLIP) m = vcc_pkg::ULAW_CLIP;
      m = m + vcc_pkg::ULAW_ADD;
      for (int i = 0; i < 8; i++) begin
        if (m >= (vcc_pkg::ULAW_SEG0 << i)) seg = seg + 4'h1;
      end
      man = 4'(m >> (seg + 4'h1));
    end else begin
      m    = s[PCM_W-1] ? 16'(~(s >>> 3)) : 16'(s >>> 3);
      mask = s[PCM_W-1] ? vcc_pkg::ALAW_NEG : vcc_pkg::ALAW_POS;
      for (int i = 0; i < 8; i++) begin
        if (m >= (vcc_pkg::ALAW_SEG0 << i)) seg = seg + 4'h1;
      end
      man = (seg < 4'h2) ? 4'(m >> 1) : 4'(m >> seg);
    end
    return ((seg > 4'h7) ? vcc_pkg::LOG_TOP : {seg[2:0], man}) ^ mask;
  endfunction

  function automatic logic signed [PCM_W-1:0] log_to_lin(input logic [7:0] code, input logic mu);
    logic [7:0]  c;
    logic [15:0] t;
    if (mu) begin
      c = ~code;
      t = (16'({c[3:0], 3'b000}) + vcc_pkg::ULAW_BIAS) << c[6:4];
      t = t - vcc_pkg::ULAW_BIAS;
      return c[7] ? -signed'(t) : signed'(t);
    end else begin
      c = code ^ vcc_pkg::ALAW_NEG;
      t = 16'({c[3:0], 4'b0000});
      if (c[6:4] == 3'h0) begin
        t = t + vcc_pkg::ALAW_HALF;
      end else begin
        t = (t + vcc_pkg::ALAW_BIAS) << (c[6:4] - 3'h1);
      end
      return c[7] ? signed'(t) : -signed'(t);
    end
  endfunction

  // log code from one law to the other through linear
  function automatic logic [7:0] law_map(input logic [7:0] code, input logic from_mu,
                                         input logic to_mu);
    return (from_mu == to_mu) ? code : lin_to_log(log_to_lin(code, from_mu), to_mu); // [R03]
  endfunction

  // ****************************************
  // input fifo
  // ****************************************
  logic [PCM_W-1:0] fifo_data;
  logic             fifo_valid;
  logic             fifo_pop;

  vcc_fifo #(
    .WIDTH (PCM_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_data   (line_in_data),
    .in_valid  (line_in_valid),
    .in_ready  (line_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ****************************************
  // scheme decode
  // ****************************************
  logic is_cvsd;
  logic air_mu;
  logic [7:0] air_silence;

  assign is_cvsd     = (vcc_pkg::vcc_scheme_t'(air_scheme) == vcc_pkg::VCC_AIR_CVSD); // [R02]
  assign air_mu      = (vcc_pkg::vcc_scheme_t'(air_scheme) == vcc_pkg::VCC_AIR_ULAW);
  assign air_silence = air_mu ? vcc_pkg::ULAW_SILENCE : vcc_pkg::ALAW_SILENCE;

  // ****************************************
  // transmit path
  // ****************************************
  logic [TW-1:0]           tick_q;
  logic [TW-1:0]           tick_d;
  logic                    tick;
  logic [2:0]              tx_idx_q;
  logic [2:0]              tx_idx_d;
  logic [7:0]              tx_sh_q;
  logic [7:0]              tx_sh_d;
  logic signed [ACC_W-1:0] enc_y_q;
  logic signed [ACC_W-1:0] enc_y_d;
  logic [STW-1:0]          enc_st_q;
  logic [STW-1:0]          enc_st_d;
  logic [HL-1:0]           enc_h_q;
  logic [HL-1:0]           enc_h_d;
  logic                    tx_bit_q;
  logic                    tx_bit_d;
  logic                    tx_stb_q;
  logic                    tx_stb_d;

  assign tick     = (tick_q == TICK_LAST); // [R04]
  // log pcm takes one sample per 8 bit ticks, delta modulation one per tick
  assign fifo_pop = tick & (is_cvsd | (tx_idx_q == 3'h0)); // [R01] [R04]

  always_comb begin
    logic signed [ACC_W-1:0] x;
    logic signed [ACC_W-1:0] p;
    logic                    b;
    logic [7:0]              code;
    x        = fifo_valid ? ACC_W'(signed'(fifo_data)) : '0;
    p        = cvsd_pred(enc_y_q);
    b        = (x < p); // [R05] [R06]
    code     = fifo_valid ? law_map(fifo_data[7:0], line_log_mu, air_mu) : air_silence;
    tick_d   = tick ? '0 : tick_q + 1'b1;
    tx_idx_d = tx_idx_q;
    tx_sh_d  = tx_sh_q;
    enc_y_d  = enc_y_q;
    enc_st_d = enc_st_q;
    enc_h_d  = enc_h_q;
    tx_bit_d = tx_bit_q;
    tx_stb_d = tick;
    if (tick) begin
      if (is_cvsd) begin
        enc_h_d  = {enc_h_q[HL-2:0], b}; // [R07]
        enc_st_d = cvsd_step(enc_st_q, cvsd_alpha(enc_h_d)); // [R08]
        enc_y_d  = cvsd_acc(p, b, enc_st_d); // [R09]
        tx_bit_d = b; // [R05] [R14]
        tx_idx_d = '0;
      end else if (tx_idx_q == 3'h0) begin
        tx_bit_d = code[7];
        tx_sh_d  = {code[6:0], 1'b0};
        tx_idx_d = 3'h1;
      end else begin
        tx_bit_d = tx_sh_q[7];
        tx_sh_d  = {tx_sh_q[6:0], 1'b0};
        tx_idx_d = tx_idx_q + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tick_q   <= '0;
      tx_idx_q <= '0;
      tx_sh_q  <= '0;
      enc_y_q  <= '0;
      enc_st_q <= {vcc_pkg::STEP_MIN, {vcc_pkg::STEP_SHIFT{1'b0}}};
      enc_h_q  <= 4'h5;
      tx_bit_q <= 1'b0;
      tx_stb_q <= 1'b0;
    end else begin
      tick_q   <= tick_d;
      tx_idx_q <= tx_idx_d;
      tx_sh_q  <= tx_sh_d;
      enc_y_q  <= enc_y_d;
      enc_st_q <= enc_st_d;
      enc_h_q  <= enc_h_d;
      tx_bit_q <= tx_bit_d;
      tx_stb_q <= tx_stb_d;
    end
  end

  assign air_tx_bit    = tx_bit_q;
  assign air_tx_strobe = tx_stb_q;

  // ****************************************
  // receive path
  // ****************************************
  logic signed [ACC_W-1:0] dec_y_q;
  logic signed [ACC_W-1:0] dec_y_d;
  logic [STW-1:0]          dec_st_q;
  logic [STW-1:0]          dec_st_d;
  logic [HL-1:0]           dec_h_q;
  logic [HL-1:0]           dec_h_d;
  logic [2:0]              rx_idx_q;
  logic [2:0]              rx_idx_d;
  logic [7:0]              rx_sh_q;
  logic [7:0]              rx_sh_d;
  logic                    fill_q;
  logic                    fill_d;
  logic [PCM_W-1:0]        out_q;
  logic [PCM_W-1:0]        out_d;
  logic                    out_v_q;
  logic                    out_v_d;

  always_comb begin
    logic       b;
    logic [7:0] byte_in;
    // fill: alternating bits let the delta accumulator decay to silence; log pcm fills with the silence code
    b = air_rx_lost ? (is_cvsd ? fill_q : air_silence[3'h7 - rx_idx_q]) : air_rx_bit; // [R11]
    byte_in  = {rx_sh_q[6:0], b};
    dec_y_d  = dec_y_q;
    dec_st_d = dec_st_q;
    dec_h_d  = dec_h_q;
    rx_idx_d = rx_idx_q;
    rx_sh_d  = rx_sh_q;
    fill_d   = fill_q;
    out_d    = out_q;
    out_v_d  = 1'b0;
    if (air_rx_strobe) begin
      fill_d = ~fill_q;
      if (is_cvsd) begin
        dec_h_d  = {dec_h_q[HL-2:0], b}; // [R16]
        dec_st_d = cvsd_step(dec_st_q, cvsd_alpha(dec_h_d)); // [R16]
        dec_y_d  = cvsd_acc(cvsd_pred(dec_y_q), b, dec_st_d); // [R16] [R17]
        out_d    = dec_y_d[PCM_W-1:0]; // [R10] [R13] [R16]
        out_v_d  = 1'b1;
        rx_idx_d = '0;
      end else begin
        rx_sh_d  = byte_in;
        rx_idx_d = rx_idx_q + 3'h1;
        if (rx_idx_q == 3'h7) begin
          out_d   = {8'h00, law_map(byte_in, air_mu, line_log_mu)}; // [R03]
          out_v_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      dec_y_q  <= '0;
      dec_st_q <= {vcc_pkg::STEP_MIN, {vcc_pkg::STEP_SHIFT{1'b0}}};
      dec_h_q  <= 4'h5;
      rx_idx_q <= '0;
      rx_sh_q  <= '0;
      fill_q   <= 1'b0;
      out_q    <= '0;
      out_v_q  <= 1'b0;
    end else begin
      dec_y_q  <= dec_y_d;
      dec_st_q <= dec_st_d;
      dec_h_q  <= dec_h_d;
      rx_idx_q <= rx_idx_d;
      rx_sh_q  <= rx_sh_d;
      fill_q   <= fill_d;
      out_q    <= out_d;
      out_v_q  <= out_v_d;
    end
  end

  assign line_out_data  = out_q;
  assign line_out_valid = out_v_q;

  // ****************************************
  // fec fallback
  // ****************************************
  logic [vcc_pkg::FEC_INFO_W-1:0] fec_q;
  logic [vcc_pkg::FEC_INFO_W-1:0] fec_d;
  logic                           fec_v_q;
  logic                           fec_v_d;

  always_comb begin
    fec_v_d = fec_seg_valid;
    fec_d   = fec_q;
    if (fec_seg_valid) begin
      // systematic code: raw information bits lead the segment
      fec_d = fec_uncorrectable ?
              fec_seg[vcc_pkg::FEC_SEG_W-1 -: vcc_pkg::FEC_INFO_W] : fec_corrected; // [R12]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fec_q   <= '0;
      fec_v_q <= 1'b0;
    end else begin
      fec_q   <= fec_d;
      fec_v_q <= fec_v_d;
    end
  end

  assign fec_info       = fec_q;
  assign fec_info_valid = fec_v_q;

endmodule

/* test/vcc_codec_chk.sv */
// port-level assertions of the voice codec
module vcc_codec_chk #(
  parameter int unsigned TICK_CYCLES = 8
) (
  input wire logic                           ref_clk,
  input wire logic                           rstn,
  input wire logic [1:0]                     air_scheme,
  input wire logic                           line_in_ready,
  input wire logic                           air_tx_bit,
  input wire logic                           air_tx_strobe,
  input wire logic                           air_rx_strobe,
  input wire logic [vcc_pkg::PCM_W-1:0]      line_out_data,
  input wire logic                           line_out_valid,
  input wire logic [vcc_pkg::FEC_SEG_W-1:0]  fec_seg,
  input wire logic [vcc_pkg::FEC_INFO_W-1:0] fec_corrected,
  input wire logic                           fec_uncorrectable,
  input wire logic                           fec_seg_valid,
  input wire logic [vcc_pkg::FEC_INFO_W-1:0] fec_info,
  input wire logic                           fec_info_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // strobe spacing counter
  // ****************************************
  logic [15:0] gap_q;
  logic [15:0] gap_d;
  logic        seen_q;
  logic        seen_d;
  always_comb begin
    gap_d  = (!rstn || air_tx_strobe) ? 16'h0000 : gap_q + 16'h0001;
    seen_d = rstn && (seen_q || air_tx_strobe);
  end
  always_ff @(posedge ref_clk) begin
    gap_q  <= gap_d;
    seen_q <= seen_d;
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_tick_period: assert property (air_tx_strobe && seen_q |-> gap_q == TICK_CYCLES - 1)
    else $error("transmit strobe spacing wrong");
  a_tx_single: assert property (air_tx_strobe |=> !air_tx_strobe)
    else $error("transmit strobe longer than one cycle");
  a_tx_bit_hold: assert property (!air_tx_strobe |-> $stable(air_tx_bit))
    else $error("transmit bit moved between strobes");
  a_rx_answer: assert property (air_scheme == vcc_pkg::VCC_AIR_CVSD
    && air_rx_strobe |=> line_out_valid)
    else $error("decoded sample missing after received bit");
  a_out_cause: assert property (line_out_valid |-> $past(air_rx_strobe))
    else $error("decoded sample without received bit");
  a_out_hold: assert property (!line_out_valid |-> $stable(line_out_data))
    else $error("line output moved without valid");
  a_log_upper: assert property (air_scheme != vcc_pkg::VCC_AIR_CVSD
    && line_out_valid |-> line_out_data[15:8] == 8'h00)
    else $error("log output upper byte not zero");
  a_fec_raw: assert property (fec_seg_valid && fec_uncorrectable
    |=> fec_info_valid && fec_info == 10'($past(fec_seg) >> 5))
    else $error("uncorrectable segment not passed raw");
  a_fec_fixed: assert property (fec_seg_valid && !fec_uncorrectable
    |=> fec_info_valid && fec_info == $past(fec_corrected))
    else $error("corrected segment not passed");
  a_fec_once: assert property (fec_info_valid |-> $past(fec_seg_valid))
    else $error("segment output without input");
  a_ready_pop: assert property ($rose(line_in_ready) |-> air_tx_strobe)
    else $error("fifo room appeared off the sample tick");
endmodule

bind vcc_codec vcc_codec_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .ref_clk, .rstn, .air_scheme, .line_in_ready, .air_tx_bit, .air_tx_strobe,
  .air_rx_strobe, .line_out_data, .line_out_valid, .fec_seg, .fec_corrected,
  .fec_uncorrectable, .fec_seg_valid, .fec_info, .fec_info_valid);

/* test/vcc_link_model.sv */
// link controller model: returns air bits, can flag them lost
module vcc_link_model (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic tx_bit,
  input  wire logic tx_strobe,
  input  wire logic lose_en,
  output logic      rx_bit,
  output logic      rx_strobe,
  output logic      rx_lost
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  initial begin
    rx_bit    = 1'b0;
    rx_strobe = 1'b0;
    rx_lost   = 1'b0;
  end
  // off-strobe the line shows junk, never the held bit
  always @(negedge ref_clk) begin
    rx_strobe <= rstn & tx_strobe;
    rx_bit    <= tx_strobe ? tx_bit ^ lose_en : ~last; // lost bits arrive corrupted
    rx_lost   <= tx_strobe & lose_en;
    if (tx_strobe) begin
      last <= tx_bit;
    end
  end
endmodule

/* test/vcc_codec_bench.sv */
// self-checking bench of the voice codec
module vcc_codec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TC = 8;
  // a-law silence re-coded as mu-law; the mixed-law run sends silence only
  localparam logic [7:0]  A2U_SIL = 8'hFE;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [1:0]  air_scheme = 2'b00;
  logic        line_log_mu = 1'b0;
  logic [15:0] line_in_data = 16'h0000;
  logic        line_in_valid = 1'b0;
  logic        lose_en = 1'b0;
  logic [14:0] fec_seg = 15'h0000;
  logic [9:0]  fec_corrected = 10'h000;
  logic        fec_uncorrectable = 1'b0;
  logic        fec_seg_valid = 1'b0;
  logic        line_in_ready, air_tx_bit, air_tx_strobe, air_rx_bit, air_rx_strobe;
  logic        air_rx_lost, line_out_valid, fec_info_valid;
  logic [15:0] line_out_data;
  logic [9:0]  fec_info;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          seed = 32'h717232E3;
  int          y_m, st_m, nb;
  logic [3:0]  h_m;
  logic [7:0]  cur;
  logic [15:0] x;
  logic        b;
  logic        chk_out = 1'b0;
  logic [15:0] inq[$];
  logic [15:0] outq[$];

  always #5 ref_clk = ~ref_clk;

  vcc_codec #(.TICK_CYCLES(TC), .FIFO_DEPTH(16)) i_dut (
    .ref_clk, .rstn, .air_scheme, .line_log_mu, .line_in_data, .line_in_valid,
    .line_in_ready, .air_tx_bit, .air_tx_strobe, .air_rx_bit, .air_rx_strobe,
    .air_rx_lost, .line_out_data, .line_out_valid, .fec_seg, .fec_corrected,
    .fec_uncorrectable, .fec_seg_valid, .fec_info, .fec_info_valid);

  vcc_link_model i_link (
    .ref_clk, .rstn, .tx_bit(air_tx_bit), .tx_strobe(air_tx_strobe), .lose_en,
    .rx_bit(air_rx_bit), .rx_strobe(air_rx_strobe), .rx_lost(air_rx_lost));

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #200_000;
    n_mismatch++;
    test_done();
  end

  // ****************************************
  // delta modulation reference, one sample
  // ****************************************
  task automatic dm_upd(input logic bit_in);
    int p;
    p = y_m - (y_m >>> 5);
    h_m = {h_m[2:0], bit_in};
    if (h_m == 4'h0 || h_m == 4'hF) st_m = (st_m + 10240 > 1310720) ? 1310720 : st_m + 10240;
    else st_m = (st_m - (st_m >>> 10) < 10240) ? 10240 : st_m - (st_m >>> 10);
    y_m = bit_in ? p - (st_m >>> 10) : p + (st_m >>> 10);
    if (y_m > 32767) y_m = 32767;
    if (y_m < -32768) y_m = -32768;
  endtask

  // ****************************************
  // monitor: air bits and decoded samples
  // ****************************************
  always @(negedge ref_clk) begin
    if (rstn && air_tx_strobe) begin
      if (air_scheme != vcc_pkg::VCC_AIR_CVSD) begin
        if (nb == 0) begin
          cur = (inq.size() > 0) ? inq[0][7:0] : ((air_scheme == vcc_pkg::VCC_AIR_ULAW)
            ? vcc_pkg::ULAW_SILENCE : vcc_pkg::ALAW_SILENCE);
          if (inq.size() > 0) void'(inq.pop_front());
          outq.push_back({8'h00, (line_log_mu == (air_scheme == vcc_pkg::VCC_AIR_ULAW))
            ? cur : A2U_SIL});
        end
        check(16'(air_tx_bit), 16'(cur[7 - nb]));
        nb = (nb + 1) % 8;
      end else begin
        x = (inq.size() > 0) ? inq.pop_front() : 16'h0000;
        b = $signed(x) < (y_m - (y_m >>> 5));
        check(16'(air_tx_bit), 16'(b));
        dm_upd(b);
        outq.push_back(16'(y_m));
      end
    end
    if (rstn && chk_out && line_out_valid) begin
      check(line_out_data, (outq.size() > 0) ? outq.pop_front() : 16'hXXXX);
    end
  end

  // ****************************************
  // stimulus
  // ****************************************
  // small delta noise for the first 60 samples, then full-scale high and low; log pcm gets random words
  function automatic logic [15:0] nxt(input int i, input logic [1:0] sc);
    logic [15:0] r;
    r = 16'($random(seed));
    if (sc != 2'b00) return r;
    if (i < 60) return {{11{r[4]}}, r[4:0]};
    return (i < 200) ? 16'h7FFF : 16'h8000;
  endfunction

  // scheme is fixed under reset, before any traffic
  task automatic run_phase(input logic [1:0] sc, input logic mu, input int n, input logic ck);
    int i;
    logic [15:0] w;
    @(negedge ref_clk);
    rstn = 1'b0;
    air_scheme = sc;
    line_log_mu = mu;
    lose_en = 1'b0;
    chk_out = ck;
    inq.delete();
    outq.delete();
    y_m = 0;
    st_m = 10240;
    h_m = 4'h5;
    nb = 0;
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    i = 0;
    w = nxt(i, sc);
    while (i < n) begin
      @(negedge ref_clk);
      line_in_data = w;
      line_in_valid = 1'b1;
      if (line_in_ready === 1'b1) begin
        inq.push_back(w);
        i++;
        w = nxt(i, sc);
      end
    end
    @(negedge ref_clk);
    line_in_valid = 1'b0;
    for (i = 0; i < 4000 && inq.size() > 0; i++) @(negedge ref_clk);
    check(16'(inq.size()), 16'h0000);
    repeat (40 * TC) @(negedge ref_clk);
    chk_out = ck && (sc != 2'b00);
    lose_en = 1'b1;
    repeat (16 * TC) @(negedge ref_clk);
  endtask

  initial begin
    int i;
    logic [9:0] pe;
    run_phase(2'b00, 1'b0, 340, 1'b1);
    run_phase(2'b01, 1'b0, 40, 1'b1);
    run_phase(2'b10, 1'b1, 0, 1'b1);
    run_phase(2'b11, 1'b1, 0, 1'b1);
    pe = 10'h000;
    for (i = 0; i < 200; i++) begin
      @(negedge ref_clk);
      if (i > 0) begin
        check(16'(fec_info_valid), 16'h0001);
        check(16'(fec_info), 16'(pe));
      end
      fec_seg = 15'($random(seed));
      fec_corrected = 10'($random(seed));
      fec_uncorrectable = 1'($random(seed));
      pe = fec_uncorrectable ? fec_seg[14:5] : fec_corrected;
      fec_seg_valid = (i < 199);
    end
    test_done();
  end
endmodule
